// File: src/alt_pkg.sv
package alt_pkg;
   // instruction word and data widths
   localparam int unsigned ALT_INSTR_W = 10;
   localparam int unsigned ALT_DATA_W = 4;
   localparam int unsigned ALT_NUM_OPS = 6;

   // opcodes of the six transfer instructions
   localparam logic [9:0] ALT_OP_LOAD_ACC_FROM_TCTL_THREE = 10'h24d;
   localparam logic [9:0] ALT_OP_LOAD_ACC_FROM_TCTL_FOUR = 10'h24e;
   localparam logic [9:0] ALT_OP_LOAD_ACC_FROM_TCTL_FIVE = 10'h24f;
   localparam logic [9:0] ALT_OP_LOAD_ACC_FROM_TCTL_SIX = 10'h250;
   localparam logic [9:0] ALT_OP_LOAD_ACC_FROM_POINTER_ONE = 10'h052;
   localparam logic [9:0] ALT_OP_LOAD_ACC_FROM_POINTER_TWO = 10'h01f;

   // index of each instruction in the match vector
   localparam int unsigned ALT_IDX_TCTL_THREE = 0;
   localparam int unsigned ALT_IDX_TCTL_FOUR = 1;
   localparam int unsigned ALT_IDX_TCTL_FIVE = 2;
   localparam int unsigned ALT_IDX_TCTL_SIX = 3;
   localparam int unsigned ALT_IDX_POINTER_ONE = 4;
   localparam int unsigned ALT_IDX_POINTER_TWO = 5;

   // opcode table, in match-vector order
   localparam logic [9:0] ALT_OPCODES [ALT_NUM_OPS] = '{
      ALT_OP_LOAD_ACC_FROM_TCTL_THREE,
      ALT_OP_LOAD_ACC_FROM_TCTL_FOUR,
      ALT_OP_LOAD_ACC_FROM_TCTL_FIVE,
      ALT_OP_LOAD_ACC_FROM_TCTL_SIX,
      ALT_OP_LOAD_ACC_FROM_POINTER_ONE,
      ALT_OP_LOAD_ACC_FROM_POINTER_TWO
   };

   // accumulator value after reset, words and cycles per instruction
   localparam logic [3:0] ALT_ACC_RESET = 4'h0;
   localparam int unsigned ALT_WORDS_PER_OP = 1;
   localparam int unsigned ALT_CYCLES_PER_OP = 1;
endpackage : alt_pkg

// File: src/alt_opcode_match.sv
`timescale 1ns/1ns
module alt_opcode_match
   import alt_pkg::*;
#(
   parameter logic [9:0] OPCODE = 10'h000
)
(
   // instruction in
   input wire logic valid_i,
   input wire logic [9:0] instr_i,
   // match out
   output logic hit_o
);
   // whole-word compare, so each opcode is unique
   assign hit_o = valid_i && (instr_i == OPCODE);
endmodule : alt_opcode_match

// File: src/alt_core.sv
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
module alt_core
   import alt_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic en_i,
   // decoded instruction word
   input wire logic instr_valid_i,
   input wire logic [9:0] instr_i,
   // source registers
   input wire logic [3:0] timer_control_three_i,
   input wire logic [3:0] timer_control_four_i,
   input wire logic [3:0] timer_control_five_i,
   input wire logic [3:0] timer_control_six_i,
   input wire logic [3:0] pointer_one_i,
   input wire logic [3:0] pointer_two_i,
   // accumulator writes from other instruction groups
   input wire logic acc_ext_we_i,
   input wire logic [3:0] acc_ext_data_i,
   // results
   output logic [3:0] acc_o,
   output logic acc_load_o,
   output logic carry_we_o,
   output logic skip_o
);

   //////////////////////////////////////////////////////////////////////////
   // opcode decode

   logic [ALT_NUM_OPS-1:0] hit;

   // one matcher per transfer instruction
   for (genvar g = 0; g < ALT_NUM_OPS; g++)
   begin : g_match
      alt_opcode_match #(
         .OPCODE(ALT_OPCODES[g])
      ) u_match (
         .valid_i(instr_valid_i),
         .instr_i(instr_i),
         .hit_o(hit[g])
      );
   end

   //////////////////////////////////////////////////////////////////////////
   // accumulator path

   logic [3:0] acc;
   logic acc_load;
   logic carry_we;
   logic skip;
   logic [3:0] next_acc;
   logic next_acc_load;
   logic next_carry_we;
   logic next_skip;

   // source select, one cycle per instruction
   always_comb
   begin
      next_acc = acc;
      next_acc_load = 1'b1;
      next_carry_we = 1'b0;
      next_skip = 1'b0;
      if (hit[ALT_IDX_TCTL_THREE])
      begin
         next_acc = timer_control_three_i;
      end
      else if (hit[ALT_IDX_TCTL_FOUR])
      begin
         next_acc = timer_control_four_i;
      end
      else if (hit[ALT_IDX_TCTL_FIVE])
      begin
         next_acc = timer_control_five_i;
      end
      else if (hit[ALT_IDX_TCTL_SIX])
      begin
         next_acc = timer_control_six_i;
      end
      else if (hit[ALT_IDX_POINTER_ONE])
      begin
         next_acc = pointer_one_i;
      end
      else if (hit[ALT_IDX_POINTER_TWO])
      begin
         next_acc = pointer_two_i;
      end
      else
      begin
         next_acc_load = 1'b0;
         if (acc_ext_we_i)
         begin
            next_acc = acc_ext_data_i;
         end
      end
   end

   // registers, frozen while enable is low
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         acc <= ALT_ACC_RESET;
         acc_load <= 1'b0;
         carry_we <= 1'b0;
         skip <= 1'b0;
      end
      else if (en_i)
      begin
         acc <= next_acc;
         acc_load <= next_acc_load;
         carry_we <= next_carry_we;
         skip <= next_skip;
      end
   end

   assign acc_o = acc;
   assign acc_load_o = acc_load;
   assign carry_we_o = carry_we;
   assign skip_o = skip;

   //////////////////////////////////////////////////////////////////////////
   // checks

   // a transfer seen at an enabled edge
   sequence s_take(logic [9:0] op);
      en_i && instr_valid_i && instr_i == op;
   endsequence

   a_tctl_five_load: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      s_take(ALT_OP_LOAD_ACC_FROM_TCTL_FIVE) |=>
         acc_o == $past(timer_control_five_i) && acc_load_o)
      else $error("tctl five not loaded in one cycle");

   a_tctl_six_load: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      s_take(ALT_OP_LOAD_ACC_FROM_TCTL_SIX) |=>
         acc_o == $past(timer_control_six_i) && acc_load_o)
      else $error("tctl six not loaded in one cycle");

   a_tctl_four_load: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      s_take(ALT_OP_LOAD_ACC_FROM_TCTL_FOUR) |=>
         acc_o == $past(timer_control_four_i) && acc_load_o)
      else $error("tctl four not loaded in one cycle");

   a_pointer_one_load: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      s_take(ALT_OP_LOAD_ACC_FROM_POINTER_ONE) |=>
         acc_o == $past(pointer_one_i) && acc_load_o)
      else $error("pointer one not loaded in one cycle");

   a_pointer_two_load: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      s_take(ALT_OP_LOAD_ACC_FROM_POINTER_TWO) |=>
         acc_o == $past(pointer_two_i) && acc_load_o)
      else $error("pointer two not loaded in one cycle");

   a_tctl_three_load: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      s_take(ALT_OP_LOAD_ACC_FROM_TCTL_THREE) |=>
         acc_o == $past(timer_control_three_i) && acc_load_o)
      else $error("tctl three not loaded in one cycle");

   a_no_carry_skip: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (en_i && |hit) |=> !carry_we_o && !skip_o)
      else $error("transfer touched carry or skip");

   a_unique_decode: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      $onehot0(hit))
      else $error("opcode matched two transfers");

   a_foreign_no_load: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (en_i && !(|hit)) |=> !acc_load_o)
      else $error("load pulse without a transfer opcode");

   // an enabled edge that writes from another group
   sequence s_ext_write;
      en_i && !(|hit) && acc_ext_we_i;
   endsequence

   // the write lands and raises no load pulse
   a_ext_write_land: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      s_ext_write |=> acc_o == $past(acc_ext_data_i) && !acc_load_o)
      else $error("external write did not land");

   // an enabled edge with no transfer and no write
   sequence s_quiet;
      en_i && !(|hit) && !acc_ext_we_i;
   endsequence

   // nothing to do, so the accumulator holds
   a_quiet_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      s_quiet |=> $stable(acc_o) && !acc_load_o)
      else $error("accumulator moved without a write");

   // an edge with the clock enable low
   sequence s_frozen;
      !en_i;
   endsequence

   // disabled edges leave every output as it was
   a_enable_freeze: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      s_frozen |=> $stable(acc_o) && $stable(acc_load_o) && $stable(carry_we_o) && $stable(skip_o))
      else $error("state changed while enable was low");

   // an enabled edge with no valid instruction word
   sequence s_no_instr;
      en_i && !instr_valid_i;
   endsequence

   // an invalid word never counts as a transfer
   a_valid_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      s_no_instr |=> !acc_load_o)
      else $error("load pulse without a valid instruction");

endmodule : alt_core

// File: tb/alt_core_tb.sv
`timescale 1ns/1ns
module tb;
   import alt_pkg::*;
   // clock, reset and stimulus
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic en_i = 1'b1;
   logic instr_valid_i = 1'b0;
   logic [9:0] instr_i = 10'h000;
   logic acc_ext_we_i = 1'b0;
   logic [3:0] acc_ext_data_i = 4'h0;
   logic [3:0] src [6] = '{4'h3, 4'hc, 4'h5, 4'ha, 4'h6, 4'h9};
   // results
   logic [3:0] acc_o;
   logic acc_load_o;
   logic carry_we_o;
   logic skip_o;
   int errors = 0;
   int compares = 0;
   //////////////////////////////////////////////////////////////////////////////
   alt_core u_alt_core (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .en_i(en_i),
      .instr_valid_i(instr_valid_i), .instr_i(instr_i),
      .timer_control_three_i(src[0]), .timer_control_four_i(src[1]),
      .timer_control_five_i(src[2]), .timer_control_six_i(src[3]),
      .pointer_one_i(src[4]), .pointer_two_i(src[5]),
      .acc_ext_we_i(acc_ext_we_i), .acc_ext_data_i(acc_ext_data_i),
      .acc_o(acc_o), .acc_load_o(acc_load_o), .carry_we_o(carry_we_o), .skip_o(skip_o)
   );
   // 20 ns clock
   initial
   begin
      forever #10 clk_i = ~clk_i;
   end
   //////////////////////////////////////////////////////////////////////////////
   // one compare
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // drive one cycle from a falling edge to the next
   task automatic drive(input logic v, input logic [9:0] op, input logic we, input logic [3:0] d);
      instr_valid_i = v;
      instr_i = op;
      acc_ext_we_i = we;
      acc_ext_data_i = d;
      @(negedge clk_i);
   endtask : drive
   // accumulator, load pulse, no carry write, no skip
   task automatic chk_out(input logic [3:0] acc, input logic ld);
      chk(acc_o, acc);
      chk({3'h0, acc_load_o}, {3'h0, ld});
      chk({2'h0, carry_we_o, skip_o}, 4'h0);
   endtask : chk_out
   //////////////////////////////////////////////////////////////////////////////
   // all six transfers back to back, then an idle cycle
   task automatic test_all_ops();
      for (int i = 0; i < 6; i++)
      begin
         drive(1'b1, ALT_OPCODES[i], 1'b0, 4'h0);
         chk_out(src[i], 1'b1);
      end
      drive(1'b0, ALT_OPCODES[0], 1'b0, 4'h0);
      chk_out(src[5], 1'b0);
      $display("test_all_ops done");
   endtask : test_all_ops
   // neighbouring opcodes are not transfers
   task automatic test_refused();
      logic [9:0] near [5] = '{10'h24b, 10'h251, 10'h053, 10'h01e, 10'h24c};
      for (int i = 0; i < 5; i++)
      begin
         drive(1'b1, near[i], 1'b0, 4'h0);
         chk_out(src[5], 1'b0);
      end
      $display("test_refused done");
   endtask : test_refused
   // external write, then transfer beating a same-cycle write
   task automatic test_priority();
      drive(1'b0, 10'h000, 1'b1, 4'h7);
      chk_out(4'h7, 1'b0);
      drive(1'b1, ALT_OP_LOAD_ACC_FROM_TCTL_FIVE, 1'b1, 4'h1);
      chk_out(src[2], 1'b1);
      $display("test_priority done");
   endtask : test_priority
   // disabled edges take nothing
   task automatic test_enable();
      drive(1'b0, 10'h000, 1'b0, 4'h0);
      en_i = 1'b0;
      drive(1'b1, ALT_OP_LOAD_ACC_FROM_TCTL_SIX, 1'b0, 4'h0);
      chk_out(src[2], 1'b0);
      en_i = 1'b1;
      drive(1'b1, ALT_OP_LOAD_ACC_FROM_TCTL_SIX, 1'b0, 4'h0);
      chk_out(src[3], 1'b1);
      $display("test_enable done");
   endtask : test_enable
   // a source changed in the taking cycle is seen at once
   task automatic test_fresh();
      src[1] = 4'he;
      drive(1'b1, ALT_OP_LOAD_ACC_FROM_TCTL_FOUR, 1'b0, 4'h0);
      chk_out(4'he, 1'b1);
      src[1] = 4'hc;
      drive(1'b1, ALT_OP_LOAD_ACC_FROM_POINTER_ONE, 1'b0, 4'h0);
      chk_out(src[4], 1'b1);
      $display("test_fresh done");
   endtask : test_fresh
   // reset in mid-run clears at once
   task automatic test_reset();
      arst_n_i = 1'b0;
      #1;
      chk_out(4'h0, 1'b0);
      drive(1'b0, 10'h000, 1'b0, 4'h0);
      arst_n_i = 1'b1;
      drive(1'b1, ALT_OP_LOAD_ACC_FROM_POINTER_TWO, 1'b0, 4'h0);
      chk_out(src[5], 1'b1);
      $display("test_reset done");
   endtask : test_reset
   //////////////////////////////////////////////////////////////////////////////
   // verdict
   task automatic complete_run();
      $display("compares=%0d errors=%0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : complete_run
   // main sequence
   initial
   begin
      repeat (5) @(negedge clk_i);
      arst_n_i = 1'b1;
      test_all_ops();
      test_refused();
      test_priority();
      test_enable();
      test_fresh();
      test_reset();
      complete_run();
   end
endmodule : tb
